//--- hdl/nvm_pkg.sv
/*
 * Shared constants and types of the self-write memory access controller:
 * register offsets, control bit positions, unlock pattern, timing and state.
 * Assumes a single 50 MHz core clock and an 8-bit register port.
 */
`default_nettype none

package nvm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_MHZ             = 50;
    localparam int ERASE_TIME_US       = 2000;  // self-timed row erase
    localparam int EE_WRITE_TIME_US    = 2000;  // self-timed eeprom byte write
    localparam int ERASE_CYCLES_DEF    = ERASE_TIME_US * CLK_MHZ;
    localparam int EE_WRITE_CYCLES_DEF = EE_WRITE_TIME_US * CLK_MHZ;
    localparam int CNT_W               = 24;

    ////////////////////////////////////////////////////////////////////////////
    // geometry
    localparam int          ROW_WORDS   = 32;
    localparam int          ROW_LSB     = 5;
    localparam int          PM_WORD_W   = 14;
    localparam logic [13:0] ERASED_WORD = 14'h3fff;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [2:0] OFS_ADDR_LOW  = 3'h0;
    localparam logic [2:0] OFS_ADDR_HIGH = 3'h1;
    localparam logic [2:0] OFS_DATA_LOW  = 3'h2;
    localparam logic [2:0] OFS_DATA_HIGH = 3'h3;
    localparam logic [2:0] OFS_CONTROL   = 3'h4;
    localparam logic [2:0] OFS_UNLOCK    = 3'h5;
    localparam logic [2:0] OFS_DONE      = 3'h6;

    // control register bit positions
    localparam int CTL_PGM   = 7;
    localparam int CTL_CFG   = 6;
    localparam int CTL_ERASE = 4;
    localparam int CTL_ABORT = 3;
    localparam int CTL_ALLOW = 2;
    localparam int CTL_WR    = 1;
    localparam int CTL_RD    = 0;
    localparam int DONE_BIT  = 0;

    // unlock pattern
    localparam logic [7:0] UNLOCK_FIRST  = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'haa;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_t;

    typedef enum logic [1:0] {
        UNL_IDLE      = 2'b00,
        UNL_GOT_FIRST = 2'b01,
        UNL_ARMED     = 2'b10
    } unlock_state_t;

    typedef enum logic [1:0] {
        OP_IDLE     = 2'b00,
        OP_PM_EXEC  = 2'b01,
        OP_PM_FETCH = 2'b10,
        OP_BUSY     = 2'b11
    } op_state_t;

    typedef struct packed {
        logic [7:0]       addr_low;
        logic [6:0]       addr_high;
        logic [7:0]       data_low;
        logic [5:0]       data_high;
        logic             pgm_sel;
        logic             cfg_sel;
        logic             erase_sel;
        logic             write_allow;
        logic             wr_strobe;
        logic             rd_strobe;
        logic             done_flag;
        unlock_state_t    unl;
        op_state_t        op;
        logic             op_erase;
        logic [CNT_W-1:0] cnt;
        logic [7:0]       rdata;
    } core_t;

    // state that must survive the device reset
    typedef struct packed {
        logic live;
        logic abort;
    } keep_t;

    localparam core_t CORE_RST = '0;
    localparam keep_t KEEP_RST = '0;

endpackage : nvm_pkg

`default_nettype wire

//--- hdl/self_write_memory_access.sv
/*
 * Self-write memory access controller: data eeprom and program flash
 * read, eeprom byte write and program row erase behind an 8-bit register port.
 * Assumes the core drives the register port on clk, honours fetch_suppress,
 * and holds por_b low only at power-up while rst_b covers every reset.
 */
`default_nettype none

// What this block does
// - data space read strobe puts the eeprom byte in data low next cycle
// - data low keeps the read byte until another read or a software write
// - eeprom reads ignore the data protection setting
// - byte write needs 55h, then AAh, then write strobe, each byte
// - write strobe refuses to set while write allow is clear
// - write allow changes only by software, never by hardware
// - clearing write allow leaves a started write running to completion
// - write completion clears the write strobe and sets the done flag
// - done flag stays set until software clears it
// - program read uses the second cycle; second following instruction is ignored
// - program word then appears in data low and data high next cycle
// - both data registers keep the word until another read or write
// - program erase works on 32-word rows; low five address bits ignored
// - row erase needs address, config clear, program and erase set, unlock, strobe
// - erase select is cleared by hardware when the erase completes
// - write abort flag sets when a reset interrupts a running write
// - unlock port always reads as zero
// - reset selects data eeprom space with program select clear
module self_write_memory_access
    import nvm_pkg::*;
#(
    parameter int EE_AW           = 8,
    parameter int PM_AW           = 15,
    parameter int EE_WRITE_CYCLES = EE_WRITE_CYCLES_DEF,
    parameter int ERASE_CYCLES    = ERASE_CYCLES_DEF
) (
    input  wire logic     clk,
    input  wire logic     rst_b,
    input  wire logic     por_b,
    input  wire bus_req_t bus_req,
    output logic [7:0]    bus_rdata,
    output logic          write_done_flag,
    output logic          fetch_suppress,
    output logic          nvm_busy
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks
    // counters must hold the load value, address widths must
    // fit the address registers and leave at least two rows
    if (EE_AW < 1 || EE_AW > 8) begin : g_bad_ee_aw
        $error("EE_AW must lie in 1..8");
    end
    if (PM_AW <= ROW_LSB || PM_AW > 15) begin : g_bad_pm_aw
        $error("PM_AW must lie in 6..15");
    end
    if (EE_WRITE_CYCLES < 1 || EE_WRITE_CYCLES >= (1 << CNT_W)) begin : g_bad_ee_cyc
        $error("EE_WRITE_CYCLES out of counter range");
    end
    if (ERASE_CYCLES < 1 || ERASE_CYCLES >= (1 << CNT_W)) begin : g_bad_er_cyc
        $error("ERASE_CYCLES out of counter range");
    end

    localparam logic [CNT_W-1:0] EE_LOAD    = CNT_W'(EE_WRITE_CYCLES - 1);
    localparam logic [CNT_W-1:0] ERASE_LOAD = CNT_W'(ERASE_CYCLES - 1);

    // register map, read data one cycle after the read strobe
    //   0 address low: eeprom address, program address 7..0
    //   1 address high: program address 14..8, bit 7 reads 0
    //   2 data low: eeprom byte, program word 7..0
    //   3 data high: program word 13..8, bits 7..6 read 0
    //   4 control, bit 7 down to bit 0: program select,
    //     config select, spare, erase select, write abort,
    //     write allow, write strobe, read strobe
    //   5 unlock port: write only, reads zero
    //   6 done flag in bit 0, cleared by software
    //   7 unused: reads zero, writes dropped
    // strobe bits: set by software only, a written 0 is ignored,
    //   hardware clears them when the operation ends
    // erase select: frozen while busy, cleared by hardware
    //   after the row erase
    // write abort: software may write it, hardware set wins

    ////////////////////////////////////////////////////////////////////////////
    // storage arrays, no reset: contents are nonvolatile
    logic [7:0]           ee_mem [2**EE_AW];
    logic [PM_WORD_W-1:0] pm_mem [2**PM_AW];

    core_t                q;
    core_t                d;
    keep_t                kq;
    keep_t                kd;
    logic                 ee_we;
    logic                 pm_erase;
    logic                 start;
    logic [14:0]          full_addr;
    logic [PM_AW-1:0]     pm_index;
    logic [PM_AW-1:0]     row_base;
    logic [EE_AW-1:0]     ee_index;
    logic [PM_WORD_W-1:0] pm_word;
    logic [7:0]           ee_byte;

    // address forms used by the memories
    // program index keeps the low PM_AW bits; the eeprom
    // index uses the low address byte only
    assign full_addr = {q.addr_high, q.addr_low};
    assign pm_index  = full_addr[PM_AW-1:0];
    assign row_base  = {pm_index[PM_AW-1:ROW_LSB], ROW_LSB'(0)};
    assign ee_index  = q.addr_low[EE_AW-1:0];
    assign pm_word   = pm_mem[pm_index];
    assign ee_byte   = ee_mem[ee_index];

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        d        = q;
        kd       = kq;
        ee_we    = 1'b0;
        pm_erase = 1'b0;
        start    = 1'b0;
        d.rdata  = 8'h00;  // read data stands for one cycle only

        // register reads
        // reads have no side effects, no flag is cleared here
        if (bus_req.rd) begin
            case (bus_req.addr)
                OFS_ADDR_LOW:  d.rdata = q.addr_low;
                OFS_ADDR_HIGH: d.rdata = {1'b0, q.addr_high};
                OFS_DATA_LOW:  d.rdata = q.data_low;
                OFS_DATA_HIGH: d.rdata = {2'b00, q.data_high};
                OFS_CONTROL:   d.rdata = {q.pgm_sel, q.cfg_sel, 1'b0, q.erase_sel,
                                          kq.abort, q.write_allow, q.wr_strobe,
                                          q.rd_strobe};
                OFS_UNLOCK:    d.rdata = 8'h00;
                OFS_DONE:      d.rdata = {7'h00, q.done_flag};
                default:       d.rdata = 8'h00;
            endcase
        end

        // register writes; address and data are frozen while a write runs
        if (bus_req.wr) begin
            case (bus_req.addr)
                OFS_ADDR_LOW: begin
                    if (q.op != OP_BUSY) begin
                        d.addr_low = bus_req.wdata;
                    end
                end
                OFS_ADDR_HIGH: begin
                    if (q.op != OP_BUSY) begin
                        d.addr_high = bus_req.wdata[6:0];
                    end
                end
                OFS_DATA_LOW: begin
                    if (q.op != OP_BUSY) begin
                        d.data_low = bus_req.wdata;
                    end
                end
                OFS_DATA_HIGH: begin
                    if (q.op != OP_BUSY) begin
                        d.data_high = bus_req.wdata[5:0];
                    end
                end
                OFS_CONTROL: begin
                    d.pgm_sel     = bus_req.wdata[CTL_PGM];
                    d.cfg_sel     = bus_req.wdata[CTL_CFG];
                    // only software moves this bit, even mid-write
                    d.write_allow = bus_req.wdata[CTL_ALLOW];
                    kd.abort      = bus_req.wdata[CTL_ABORT];
                    if (q.op != OP_BUSY) begin
                        d.erase_sel = bus_req.wdata[CTL_ERASE];
                    end
                    if (bus_req.wdata[CTL_RD] && q.op == OP_IDLE) begin
                        if (!d.pgm_sel && !d.cfg_sel) begin
                            // protection setting is not consulted here
                            d.data_low = ee_byte;
                        end else if (d.pgm_sel && !d.cfg_sel) begin
                            d.rd_strobe = 1'b1;
                            d.op        = OP_PM_EXEC;
                        end else begin
                            // configuration space is not served: clear data
                            d.data_low  = 8'h00;
                            d.data_high = 6'h00;
                        end
                    end else if (bus_req.wdata[CTL_WR] && q.op == OP_IDLE
                                 && q.unl == UNL_ARMED
                                 && q.write_allow
                                 && !d.cfg_sel
                                 && (!d.pgm_sel || d.erase_sel)) begin
                        // allow judged from before this store, so allow
                        // and strobe in one store is refused; selects
                        // use new values so one store picks the space
                        start = 1'b1;
                    end
                end
                OFS_UNLOCK: begin
                    // exact order 55h then aah, anything else restarts
                    // idle -> got first on 55h -> armed on aah
                    // a stray store between steps costs a full retry,
                    // the strobe store itself spends the arming
                    // reads leave it alone, so polling is harmless
                    if (bus_req.wdata == UNLOCK_FIRST) begin
                        d.unl = UNL_GOT_FIRST;
                    end else if (bus_req.wdata == UNLOCK_SECOND
                                 && q.unl == UNL_GOT_FIRST) begin
                        d.unl = UNL_ARMED;
                    end else begin
                        d.unl = UNL_IDLE;
                    end
                end
                OFS_DONE: begin
                    d.done_flag = bus_req.wdata[DONE_BIT];
                end
                default: ;
            endcase
            // every strobe write consumes the unlock, so each byte re-arms
            if (bus_req.addr != OFS_UNLOCK) begin
                d.unl = UNL_IDLE;
            end
        end

        // launch a self-timed write or row erase
        // data and address stay frozen until the end, so the
        // stored byte is the one present at the strobe
        // live marks the op for the abort tracker
        if (start) begin
            d.wr_strobe = 1'b1;
            d.op        = OP_BUSY;
            d.op_erase  = d.pgm_sel;
            d.cnt       = d.pgm_sel ? ERASE_LOAD : EE_LOAD;
            kd.live     = 1'b1;
        end

        // operation sequencing; hardware updates win over same-cycle writes
        // op states:
        //   idle      strobes may start something
        //   pm exec   core runs its next instruction normally
        //   pm fetch  flash read, core drops this instruction
        //   busy      self-timed write or erase, counter to zero
        // limitation: timing is a plain cycle count, not a cell
        //   model; a short count only speeds up simulation
        // a data store landing with the fetch is overwritten,
        //   the word read from flash is what software sees
        case (q.op)
            OP_PM_EXEC: begin
                d.op = OP_PM_FETCH;  // first following instruction runs
            end
            OP_PM_FETCH: begin
                d.data_low  = pm_word[7:0];
                d.data_high = pm_word[13:8];
                d.rd_strobe = 1'b0;
                d.op        = OP_IDLE;
            end
            OP_BUSY: begin
                if (q.cnt == '0) begin
                    d.wr_strobe = 1'b0;
                    d.done_flag = 1'b1;  // set wins over a same-cycle clear
                    d.op        = OP_IDLE;
                    kd.live     = 1'b0;
                    if (q.op_erase) begin
                        pm_erase    = 1'b1;
                        d.erase_sel = 1'b0;
                    end else begin
                        ee_we = 1'b1;
                    end
                end else begin
                    // loaded with count minus one, so busy stands
                    // for exactly the configured number of cycles
                    d.cnt = q.cnt - 1'b1;
                end
            end
            default: ;
        endcase

        // an operation marked live but not running was cut off by a reset
        if (kq.live && q.op != OP_BUSY) begin
            kd.abort = 1'b1;
            kd.live  = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // core state, cleared by every device reset
    // rst_b acts at once; its release comes from the core's
    // reset logic on a clock edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= CORE_RST;  // data space selected
        end else begin
            q <= d;
        end
    end

    // abort tracking survives device reset, cleared only at power-up or by a software write
    // why a second domain: after a device reset software must
    // still learn that a write was cut short, so only the
    // power-up reset may clear this tracker
    always_ff @(posedge clk or negedge por_b) begin
        if (!por_b) begin
            kq <= KEEP_RST;
        end else begin
            kq <= kd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // memory updates at the end of the self-timed interval
    // the byte is stored only at the end, so a reset mid-write
    // leaves the old byte in place, which the abort flag flags
    // a row erase clears all 32 words in one edge; the row base
    // masks the low address bits, so any address in the row
    // selects it
    always_ff @(posedge clk) begin
        if (ee_we) begin
            ee_mem[ee_index] <= q.data_low;
        end
        if (pm_erase) begin
            for (int i = 0; i < ROW_WORDS; i++) begin
                pm_mem[row_base | PM_AW'(i)] <= ERASED_WORD;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    // read data is zero outside its answer cycle, so an
    // or-combined read bus in the core needs no gating
    // done flag is a level for an interrupt controller;
    // this block raises no interrupt of its own
    // fetch suppress comes from registered state, clean for
    // the core's fetch logic in the same cycle
    // busy mirrors the write strobe bit
    assign bus_rdata       = q.rdata;
    assign write_done_flag = q.done_flag;
    assign fetch_suppress  = (q.op == OP_PM_FETCH);
    assign nvm_busy        = q.wr_strobe;

endmodule // self_write_memory_access

`default_nettype wire

//--- verification/nvm_access_properties.sv
/*
 * Port checker of the self-write memory access controller.
 * Assumes one clock domain and equal short self-timed counts.
 */
`default_nettype none

module nvm_access_checker
    import nvm_pkg::*;
#(
    parameter int EE_WRITE_CYCLES = 4,
    parameter int ERASE_CYCLES    = 4
) (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       por_b,
    input wire bus_req_t   bus_req,
    input wire logic [7:0] bus_rdata,
    input wire logic       write_done_flag,
    input wire logic       fetch_suppress,
    input wire logic       nvm_busy
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic [7:0] busy_len_q;
    logic       pm_rd;
    logic       done_clr;
    logic       strobe_wr;

    ////////////////////////////////////////////////////////////////////////////
    // request decodes and a run-length counter of busy
    assign pm_rd     = bus_req.wr && bus_req.addr == OFS_CONTROL && !nvm_busy
                       && bus_req.wdata[CTL_PGM] && bus_req.wdata[CTL_RD]
                       && !bus_req.wdata[CTL_CFG];
    assign done_clr  = bus_req.wr && bus_req.addr == OFS_DONE && !bus_req.wdata[DONE_BIT];
    assign strobe_wr = bus_req.wr && bus_req.addr == OFS_CONTROL && bus_req.wdata[CTL_WR];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_len_q <= '0;
        end else begin
            busy_len_q <= nvm_busy ? busy_len_q + 8'h01 : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // multi-step behaviours
    sequence suppress_s;
        !fetch_suppress ##1 fetch_suppress ##1 !fetch_suppress;
    endsequence
    sequence finish_s;
        ##[0:1] write_done_flag;
    endsequence

    AST_RDATA_IDLE: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
        else $error("read data outside the answer cycle");
    AST_UNLOCK_ZERO: assert property (
        bus_req.rd && bus_req.addr == OFS_UNLOCK |=> bus_rdata == 8'h00)
        else $error("unlock port read not zero");
    AST_STROBE_CAUSE: assert property ($rose(nvm_busy) |-> $past(strobe_wr))
        else $error("busy rose without a strobe write");
    AST_DURATION: assert property ($fell(nvm_busy) |->
        (busy_len_q == EE_WRITE_CYCLES || busy_len_q == ERASE_CYCLES))
        else $error("self-timed length wrong");
    AST_DONE_ON_END: assert property ($fell(nvm_busy) |-> finish_s)
        else $error("done flag not set at completion");
    AST_DONE_STAYS: assert property (
        $fell(write_done_flag) |-> $past(done_clr) || $past(done_clr, 2))
        else $error("done flag dropped without software clear");
    AST_SUPPRESS: assert property (pm_rd |-> ##1 suppress_s)
        else $error("fetch suppress not in second cycle");
    AST_SUPPRESS_CAUSE: assert property (fetch_suppress |-> $past(pm_rd, 2))
        else $error("fetch suppress without program read");
endmodule // nvm_access_checker

bind self_write_memory_access nvm_access_checker #(
    .EE_WRITE_CYCLES(EE_WRITE_CYCLES),
    .ERASE_CYCLES   (ERASE_CYCLES)
) chk_i (
    .clk            (clk),
    .rst_b          (rst_b),
    .por_b          (por_b),
    .bus_req        (bus_req),
    .bus_rdata      (bus_rdata),
    .write_done_flag(write_done_flag),
    .fetch_suppress (fetch_suppress),
    .nvm_busy       (nvm_busy)
);

`default_nettype wire

//--- verification/self_write_memory_access_tb_top.sv
/*
 * Bench of the self-write access controller: eeprom writes and reads,
 * unlock corner cases, row erase, program read, reset during a write.
 * Assumes short self-timed counts and a 6-bit program address.
 */
`default_nettype none

module self_write_memory_access_tb_top
    import nvm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int NCYC = 4;
    logic       clk     = 1'b0;
    logic       rst_b   = 1'b0;
    logic       por_b   = 1'b0;
    bus_req_t   bus_req = '0;
    logic [7:0] bus_rdata;
    logic       write_done_flag;
    logic       fetch_suppress;
    logic       nvm_busy;
    int         err_count  = 0;
    int         n_compared = 0;
    integer     seed       = 32'h9601449b;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] n;

    self_write_memory_access #(.EE_WRITE_CYCLES(NCYC), .ERASE_CYCLES(NCYC), .PM_AW(6)) dut (
        .clk(clk), .rst_b(rst_b), .por_b(por_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .write_done_flag(write_done_flag), .fetch_suppress(fetch_suppress), .nvm_busy(nvm_busy)
    );

    always #10 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    // bus tasks; wr and unlock leave their request up so the next may follow at once, rchk, busy and wait_done drop it
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // control byte that software should read back
    function automatic logic [7:0] exp_ctl(logic pgm, logic ers, logic abt, logic alw);
        logic [7:0] v;
        v            = 8'h00;
        v[CTL_PGM]   = pgm;
        v[CTL_ERASE] = ers;
        v[CTL_ABORT] = abt;
        v[CTL_ALLOW] = alw;
        return v;
    endfunction
    task automatic wr(logic [2:0] ad, logic [7:0] dt);
        bus_req <= '{addr: ad, wdata: dt, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
    endtask
    task automatic rchk(string nm, logic [2:0] ad, logic [7:0] exp);
        bus_req <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req <= '0;
        @(negedge clk);
        chk(nm, exp, bus_rdata);
        @(posedge clk);
    endtask
    // busy sampled mid-cycle, away from the launching edge
    task automatic busy(logic ex);
        bus_req <= '0;
        @(negedge clk);
        chk("busy", {7'h00, ex}, {7'h00, nvm_busy});
        @(posedge clk);
    endtask
    task automatic wait_done;
        logic b;
        bus_req <= '0;
        for (int k = 0; k < 50; k++) begin
            @(negedge clk);
            b = nvm_busy;
            if (b === 1'b0) break;
        end
        @(posedge clk);
        chk("wait_bound", 8'h00, {7'h00, b});
    endtask
    task automatic unlock(logic [7:0] ctl);
        wr(OFS_UNLOCK, UNLOCK_FIRST);
        wr(OFS_UNLOCK, UNLOCK_SECOND);
        wr(OFS_CONTROL, ctl);
    endtask
    // three port writes, then the strobe; ex says whether it may start
    task automatic attempt(logic [2:0] a0, logic [7:0] d0, logic [2:0] a1, logic [7:0] d1,
                           logic [2:0] a2, logic [7:0] d2, logic [7:0] ctl, logic ex);
        wr(OFS_CONTROL, ctl);
        wr(a0, d0);
        wr(a1, d1);
        wr(a2, d2);
        wr(OFS_CONTROL, ctl | 8'h02);
        busy(ex);
        wait_done;
        wr(OFS_DONE, 8'h00);
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // hang guard, far beyond the few hundred cycles of the run
    initial begin
        #200000;
        err_count++;
        end_sim;
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        por_b <= 1'b1;
        @(posedge clk);
        rchk("ctl_rst", OFS_CONTROL, exp_ctl(1'b0, 1'b0, 1'b0, 1'b0));
        rchk("done_rst", OFS_DONE, 8'h00);
        // random bytes; even passes drop write allow mid-write
        for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? 8'hff : 8'($random(seed));
            d = 8'($random(seed));
            wr(OFS_ADDR_LOW, a);
            wr(OFS_DATA_LOW, d);
            wr(OFS_CONTROL, 8'h04);
            unlock(8'h06);
            busy(1'b1);
            if (i % 2 == 0) wr(OFS_CONTROL, 8'h00);
            wait_done;
            chk("done_pin", 8'h01, {7'h00, write_done_flag});
            rchk("done_set", OFS_DONE, 8'h01);
            rchk("ctl_end", OFS_CONTROL, exp_ctl(1'b0, 1'b0, 1'b0, i % 2 != 0));
            wr(OFS_DATA_LOW, ~d);
            wr(OFS_CONTROL, 8'h01); // allow dropped once the update is over
            rchk("ee_byte", OFS_DATA_LOW, d);
            rchk("ee_hold", OFS_DATA_LOW, d);
            rchk("done_hold", OFS_DONE, 8'h01);
            wr(OFS_DONE, 8'h00);
            rchk("done_clr", OFS_DONE, 8'h00);
        end
        // unlock corner cases
        attempt(OFS_UNLOCK, 8'h55, OFS_UNLOCK, 8'h55, OFS_UNLOCK, 8'haa, 8'h04, 1);
        attempt(OFS_UNLOCK, 8'h55, OFS_UNLOCK, 8'haa, OFS_ADDR_LOW, a, 8'h04, 0);
        attempt(OFS_UNLOCK, 8'h55, OFS_DATA_LOW, d, OFS_UNLOCK, 8'haa, 8'h04, 0);
        attempt(OFS_UNLOCK, 8'haa, OFS_UNLOCK, 8'h55, OFS_UNLOCK, 8'h33, 8'h04, 0);
        attempt(OFS_UNLOCK, 8'h55, OFS_UNLOCK, 8'h55, OFS_UNLOCK, 8'haa, 8'h00, 0);
        rchk("unlock_rd", OFS_UNLOCK, 8'h00);
        // row erase from a mid-row address, then program reads in that row
        wr(OFS_ADDR_HIGH, 8'h00);
        wr(OFS_ADDR_LOW, 8'h25);
        wr(OFS_CONTROL, 8'h94);
        unlock(8'h96);
        busy(1'b1);
        wait_done;
        rchk("erase_clr", OFS_CONTROL, exp_ctl(1'b1, 1'b0, 1'b0, 1'b1));
        for (int i = 0; i < 3; i++) begin
            a = (i == 0) ? 8'h3f : (8'h20 | (8'($random(seed)) & 8'h1f));
            wr(OFS_DATA_LOW, 8'h00);
            wr(OFS_DATA_HIGH, 8'h00);
            wr(OFS_ADDR_LOW, a);
            wr(OFS_CONTROL, 8'h80); // program space selected first
            wr(OFS_CONTROL, 8'h81);
            bus_req <= '0; // idle slots follow the strobe
            n = 8'h00;
            repeat (4) begin
                @(negedge clk);
                n = n + {7'h00, fetch_suppress};
            end
            @(posedge clk);
            chk("suppress_len", 8'h01, n);
            rchk("pm_low", OFS_DATA_LOW, 8'hff);
            rchk("pm_high", OFS_DATA_HIGH, 8'h3f);
            rchk("pm_hold", OFS_DATA_LOW, 8'hff);
        end
        // reset in mid-write must leave the abort flag behind
        wr(OFS_CONTROL, 8'h04);
        unlock(8'h06);
        busy(1'b1);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        rchk("abort", OFS_CONTROL, exp_ctl(1'b0, 1'b0, 1'b1, 1'b0));
        end_sim;
    end
endmodule // self_write_memory_access_tb_top

`default_nettype wire
